//--- mcl_pkg.sv
// Package: constants, mode type and mode decoder for the output macrocell block
// Operation
// - Registers allowed 1, mode select 0, cell bit 0: combinatorial output, eight terms.
// - Combinatorial output cells feed back, except the two centre cells.
// - Registers allowed 1, mode select 0, cell bit 1: buffer off, adjacent pin fed back.
// - Dedicated input is refused on the two centre cells.
// - Registers allowed 1, mode select 1, cell bit 1: seven terms summed, eighth enables.
// - Non-registered combinatorial I/O feeds its own pin level back into the array, except the end cells, which feed back the adjacent pin.
// - Registers allowed 0, mode select 1, cell bit 1: combinatorial I/O, eighth term enables.
// - Combinatorial I/O in a registered device feeds back its own pin.
// - Registered cell captures sum xor polarity each edge; inverted feedback; shared enable.
// - With registers in use, clock and enable pins never reach the array as data.
// - First and last cells steer feedback by inverted register-allow bit.
// - Polarity bit xors the sum: 0 gives active high on combinatorial outputs and active low on registered outputs, 1 the reverse.
// - Every flip-flop starts low after reset.
// - After reset registered outputs show high; combinatorial outputs follow their logic.
// - Any register state, illegal ones too, can be loaded through the output pins.
// - Once secured, configuration readback returns nothing.
// - Security clears only together with the whole configuration during an erase.
// - A 64-bit user signature memory is kept.
// - The signature stays readable whether or not security is set.
// - Programming erases the configuration automatically, with no separate erase command.
package mcl_pkg;
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 32;
   localparam int NCELL    = 8;
   localparam int NPT      = 8;
   localparam int SIG_W    = 64;
   localparam int CENTRE_A = 3;
   localparam int CENTRE_B = 4;
   localparam int END_LO   = 0;
   localparam int END_HI   = 7;

   localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] REG_CFG    = 8'h04;
   localparam logic [ADDR_W-1:0] REG_POL    = 8'h08;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_SECURE = 8'h10;
   localparam logic [ADDR_W-1:0] REG_TEST   = 8'h14;
   localparam logic [ADDR_W-1:0] REG_SIG_LO = 8'h18;
   localparam logic [ADDR_W-1:0] REG_SIG_HI = 8'h1C;

   localparam int CTRL_SG0_BIT     = 0;
   localparam int CTRL_SG1_BIT     = 1;
   localparam int SECURE_BIT       = 0;
   localparam int TEST_PRELOAD_BIT = 0;
   localparam int STAT_SEC_BIT     = 0;
   localparam int STAT_BAD_LSB     = 8;
   localparam int STAT_Q_LSB       = 16;

   localparam logic [1:0]       CTRL_RST    = 2'h0;
   localparam logic [NCELL-1:0] CFG_RST     = 8'h00;
   localparam logic [NCELL-1:0] POL_RST     = 8'h00;
   localparam logic [SIG_W-1:0] SIG_RST     = 64'h0;
   localparam logic             SEC_RST     = 1'h0;
   localparam logic             PRELOAD_RST = 1'h0;

   typedef enum logic [2:0] {
      MCL_REG,
      MCL_IO_REGDEV,
      MCL_COMB_OUT,
      MCL_DED_IN,
      MCL_IO_COMB,
      MCL_BAD
   } mcl_mode_t;

   function automatic mcl_mode_t mcl_decode(input logic sg0,
                                            input logic sg1,
                                            input logic sl0,
                                            input logic centre);
      mcl_mode_t m;
      m = MCL_BAD;
      unique case ({sg0, sg1, sl0})
         3'h2: m = MCL_REG;
         3'h3: m = MCL_IO_REGDEV;
         3'h4: m = MCL_COMB_OUT;
         3'h5: m = centre ? MCL_BAD : MCL_DED_IN;
         3'h7: m = MCL_IO_COMB;
         default: m = MCL_BAD;
      endcase
      return m;
   endfunction : mcl_decode
endpackage : mcl_pkg

//--- mcl_sync.sv
// Two-stage synchroniser for pin levels
`timescale 1ns/100ps
`default_nettype none
module mcl_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule : mcl_sync
`default_nettype wire

//--- mcl_cell.sv
// One output macrocell: mode decode, sum, polarity, flip-flop, enable and feedback
`timescale 1ns/100ps
`default_nettype none
module mcl_cell
   import mcl_pkg::*;
#(
   parameter bit IS_END    = 1'b0,
   parameter bit IS_CENTRE = 1'b0
) (
   input  wire logic           clock,
   input  wire logic           rstn,
   input  wire logic           sg0,
   input  wire logic           sg1,
   input  wire logic           sl0,
   input  wire logic           pol,
   input  wire logic [NPT-1:0] pterms,
   input  wire logic           pin_sync,
   input  wire logic           adj_sync,
   input  wire logic           oe_pin_on,
   input  wire logic           preload,
   output logic                out_nxt,
   output logic                oe_nxt,
   output logic                fb_nxt,
   output mcl_mode_t           mode,
   output logic                q
);
   logic q_ff;
   logic sum;
   logic xor_out;
   logic fb_sel;
   logic fb_raw;
   logic io_mode;

   // centre cells decode a dedicated input as invalid
   assign mode    = mcl_decode(sg0, sg1, sl0, IS_CENTRE);
   assign io_mode = (mode == MCL_IO_REGDEV) || (mode == MCL_IO_COMB);
   // eight terms summed, or seven when the eighth is an enable
   assign sum     = io_mode ? |pterms[NPT-2:0] : |pterms;
   assign xor_out = sum ^ pol;

   // clear at reset, preload from pin, else capture in registered mode
   always_ff @(posedge clock) begin
      if (!rstn)
         q_ff <= 1'b0;
      else if (preload)
         q_ff <= pin_sync;
      else if (mode == MCL_REG)
         q_ff <= xor_out;
   end
   assign q = q_ff;

   // end cells steer feedback by the inverted register-allow bit
   assign fb_sel = IS_END ? ~sg0 : sg1;
   assign fb_raw = sl0 ? (fb_sel ? pin_sync : adj_sync)
                       : (fb_sel ? ~q_ff : (IS_CENTRE ? 1'b0 : xor_out));
   // an invalid code leaves feedback and output dead
   assign fb_nxt = (mode == MCL_BAD) ? 1'b0 : fb_raw;

   // registered output shows the inverted flop, high after reset
   assign out_nxt = (mode == MCL_REG) ? ~q_ff : (mode == MCL_BAD ? 1'b0 : xor_out);

   // buffer enable per mode, forced off during preload
   assign oe_nxt = preload ? 1'b0 :
                   (mode == MCL_REG)      ? oe_pin_on :
                   (mode == MCL_COMB_OUT) ? 1'b1 :
                   io_mode                ? pterms[NPT-1] : 1'b0;
endmodule : mcl_cell
`default_nettype wire

//--- mcl_top.sv
// Eight-cell output macrocell array with configuration, security and signature
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module mcl_top
   import mcl_pkg::*;
#(
   parameter int CELLS = NCELL
) (
   input  wire logic                 clock,
   input  wire logic                 rstn,
   input  wire logic [ADDR_W-1:0]    addr,
   input  wire logic [DATA_W-1:0]    wdata,
   input  wire logic                 wr,
   input  wire logic                 rd,
   output logic      [DATA_W-1:0]    rdata_ff,
   input  wire logic [CELLS*NPT-1:0] pterms,
   input  wire logic [CELLS-1:0]     pin_in,
   input  wire logic                 clk_pin_in,
   input  wire logic                 oe_pin_n_in,
   output logic      [CELLS-1:0]     pin_out_ff,
   output logic      [CELLS-1:0]     pin_oe_ff,
   output logic      [CELLS-1:0]     fb_ff,
   output logic                      clk_pin_arr_ff,
   output logic                      oe_pin_arr_ff
);
   logic [CELLS-1:0] pin_sync;
   logic             clk_pin_sync;
   logic             oe_pin_n_sync;

   // Pins come from the board, so every level is synchronised first
   mcl_sync #(
      .WIDTH (CELLS + 2)
   ) u_sync (
      .clock    (clock),
      .rstn     (rstn),
      .async_in ({oe_pin_n_in, clk_pin_in, pin_in}),
      .sync_out ({oe_pin_n_sync, clk_pin_sync, pin_sync})
   );

   // Configuration and test state
   logic [1:0]       ctrl_ff;
   logic [CELLS-1:0] cfg_ff;
   logic [CELLS-1:0] pol_ff;
   logic             secure_ff;
   logic             preload_ff;
   logic [SIG_W-1:0] sig_ff;

   logic [1:0]       nxt_ctrl;
   logic [CELLS-1:0] nxt_cfg;
   logic [CELLS-1:0] nxt_pol;
   logic             nxt_secure;
   logic             nxt_preload;
   logic [SIG_W-1:0] nxt_sig;
   logic [DATA_W-1:0] nxt_rdata;

   logic sg0;
   logic sg1;
   logic wr_ctrl;
   logic wr_cfg;
   logic wr_pol;
   logic wr_secure;
   logic wr_test;
   logic wr_sig_lo;
   logic wr_sig_hi;

   assign sg0 = ctrl_ff[CTRL_SG0_BIT];
   assign sg1 = ctrl_ff[CTRL_SG1_BIT];

   // Write decode
   assign wr_ctrl   = wr && (addr == REG_CTRL);
   assign wr_cfg    = wr && (addr == REG_CFG);
   assign wr_pol    = wr && (addr == REG_POL);
   assign wr_secure = wr && (addr == REG_SECURE);
   assign wr_test   = wr && (addr == REG_TEST);
   assign wr_sig_lo = wr && (addr == REG_SIG_LO);
   assign wr_sig_hi = wr && (addr == REG_SIG_HI);

   // a control write starts programming and erases configuration, polarity, security and signature
   assign nxt_ctrl = wr_ctrl ? wdata[1:0] : ctrl_ff;

   // Secured configuration is frozen until the next programming pass
   assign nxt_cfg = wr_ctrl ? CFG_RST :
                    (wr_cfg && !secure_ff) ? wdata[CELLS-1:0] : cfg_ff;
   assign nxt_pol = wr_ctrl ? POL_RST :
                    (wr_pol && !secure_ff) ? wdata[CELLS-1:0] : pol_ff;

   // security sets by its own write but clears only with the erase
   assign nxt_secure = wr_ctrl ? SEC_RST :
                       (wr_secure && wdata[SECURE_BIT]) ? 1'b1 : secure_ff;

   // signature words; writable only while unsecured, erased with the array
   assign nxt_sig = wr_ctrl ? SIG_RST :
                    (wr_sig_lo && !secure_ff) ? {sig_ff[SIG_W-1:32], wdata} :
                    (wr_sig_hi && !secure_ff) ? {wdata, sig_ff[31:0]} : sig_ff;

   assign nxt_preload = wr_test ? wdata[TEST_PRELOAD_BIT] : preload_ff;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         ctrl_ff    <= CTRL_RST;
         cfg_ff     <= CFG_RST;
         pol_ff     <= POL_RST;
         secure_ff  <= SEC_RST;
         preload_ff <= PRELOAD_RST;
         sig_ff     <= SIG_RST;
      end else begin
         ctrl_ff    <= nxt_ctrl;
         cfg_ff     <= nxt_cfg;
         pol_ff     <= nxt_pol;
         secure_ff  <= nxt_secure;
         preload_ff <= nxt_preload;
         sig_ff     <= nxt_sig;
      end
   end

   // Macrocells
   logic [CELLS-1:0] out_nxt;
   logic [CELLS-1:0] oe_nxt;
   logic [CELLS-1:0] fb_nxt;
   logic [CELLS-1:0] q_all;
   logic [CELLS-1:0] bad;
   mcl_mode_t        mode [CELLS];

   genvar gi;
   generate
      for (gi = 0; gi < CELLS; gi++) begin : g_cell
         mcl_cell #(
            .IS_END    ((gi == END_LO) || (gi == END_HI)),
            .IS_CENTRE ((gi == CENTRE_A) || (gi == CENTRE_B))
         ) u_cell (
            .clock     (clock),
            .rstn      (rstn),
            .sg0       (sg0),
            .sg1       (sg1),
            .sl0       (cfg_ff[gi]),
            .pol       (pol_ff[gi]),
            .pterms    (pterms[gi*NPT +: NPT]),
            .pin_sync  (pin_sync[gi]),
            .adj_sync  (pin_sync[gi ^ 1]),
            .oe_pin_on (~oe_pin_n_sync),
            .preload   (preload_ff),
            .out_nxt   (out_nxt[gi]),
            .oe_nxt    (oe_nxt[gi]),
            .fb_nxt    (fb_nxt[gi]),
            .mode      (mode[gi]),
            .q         (q_all[gi])
         );
         // invalid codes raise a status flag
         assign bad[gi] = (mode[gi] == MCL_BAD);
      end
   endgenerate

   // shared clock and enable pins reach the array only in combinatorial devices
   logic nxt_clk_arr;
   logic nxt_oe_arr;
   assign nxt_clk_arr = sg0 ? clk_pin_sync : 1'b0;
   assign nxt_oe_arr  = sg0 ? oe_pin_n_sync : 1'b0;

   // Read mux; data stand only in the cycle after the strobe
   logic [DATA_W-1:0] status_word;
   logic [DATA_W-1:0] read_word;
   assign status_word = {8'h00, q_all, bad, 7'h00, secure_ff};

   // secured configuration reads zero, signature never hidden
   assign read_word =
      (addr == REG_CTRL)   ? (secure_ff ? '0 : {30'h0, ctrl_ff}) :
      (addr == REG_CFG)    ? (secure_ff ? '0 : {24'h0, cfg_ff}) :
      (addr == REG_POL)    ? (secure_ff ? '0 : {24'h0, pol_ff}) :
      (addr == REG_STATUS) ? status_word :
      (addr == REG_TEST)   ? {31'h0, preload_ff} :
      (addr == REG_SIG_LO) ? sig_ff[31:0] :
      (addr == REG_SIG_HI) ? sig_ff[SIG_W-1:32] : '0;
   assign nxt_rdata = rd ? read_word : '0;

   // Pins and feedback are registered, so combinatorial paths gain one cycle
   always_ff @(posedge clock) begin
      if (!rstn) begin
         rdata_ff       <= '0;
         pin_out_ff     <= '0;
         pin_oe_ff      <= '0;
         fb_ff          <= '0;
         clk_pin_arr_ff <= 1'b0;
         oe_pin_arr_ff  <= 1'b0;
      end else begin
         rdata_ff       <= nxt_rdata;
         pin_out_ff     <= out_nxt;
         pin_oe_ff      <= oe_nxt;
         fb_ff          <= fb_nxt;
         clk_pin_arr_ff <= nxt_clk_arr;
         oe_pin_arr_ff  <= nxt_oe_arr;
      end
   end

   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   sequence s_reg_capture(int c);
      (mode[c] == MCL_REG) && !preload_ff;
   endsequence

   // A reprogrammed cell no longer shows its flop, so only a cell still registered is held to it
   sequence s_flop_shows(int c);
      ($past(mode[c]) != MCL_REG) || (pin_out_ff[c] == ~$past(q_all[c]));
   endsequence

   generate
      for (gi = 0; gi < CELLS; gi++) begin : g_chk
         // combinatorial output drives polarity-adjusted full sum
         a_comb_out_drive: assert property (
            (mode[gi] == MCL_COMB_OUT) && !preload_ff |=>
               pin_oe_ff[gi] && (pin_out_ff[gi] ==
                  $past(|pterms[gi*NPT +: NPT] ^ pol_ff[gi])))
            else $error("combinatorial output wrong");

         // dedicated input keeps buffer off and feeds the neighbour pin
         a_ded_in_off: assert property (
            (mode[gi] == MCL_DED_IN) |=>
               !pin_oe_ff[gi] && (fb_ff[gi] == $past(pin_sync[gi ^ 1])))
            else $error("dedicated input wrong");

         // eighth term enables the I/O buffer
         a_io_enable: assert property (
            ((mode[gi] == MCL_IO_REGDEV) || (mode[gi] == MCL_IO_COMB)) && !preload_ff
               |=> pin_oe_ff[gi] == $past(pterms[gi*NPT + NPT - 1]))
            else $error("I/O enable not from eighth term");

         // captured value appears inverted on the pin one cycle later
         a_reg_capture: assert property (
            s_reg_capture(gi) |=> (q_all[gi] == $past(
               |pterms[gi*NPT +: NPT] ^ pol_ff[gi])) ##1 s_flop_shows(gi))
            else $error("registered capture wrong");

         // preload loads the pin level with the buffer off
         a_preload_load: assert property (
            preload_ff |=> (q_all[gi] == $past(pin_sync[gi])) && !pin_oe_ff[gi])
            else $error("preload wrong");
      end
   endgenerate

   // centre cell CENTRE_A gives no feedback as a combinatorial output
   a_centre_no_fb: assert property (
      (mode[CENTRE_A] == MCL_COMB_OUT) |=> !fb_ff[CENTRE_A])
      else $error("centre cell feedback present");

   // dedicated input code on a centre cell is flagged
   a_ded_in_centre: assert property (
      sg0 && !sg1 && cfg_ff[CENTRE_B] |-> bad[CENTRE_B])
      else $error("centre dedicated input accepted");

   // non-end cell 1 in an I/O code feeds back its own pin
   a_io_feedback: assert property (
      ((mode[1] == MCL_IO_REGDEV) || (mode[1] == MCL_IO_COMB)) |=>
         fb_ff[1] == $past(pin_sync[1]))
      else $error("I/O feedback not own pin");

   // end cell in a non-registered I/O code follows the inverted allow bit
   a_end_fb_sel: assert property (
      (mode[END_LO] == MCL_IO_COMB) |=> fb_ff[END_LO] == $past(pin_sync[END_LO ^ 1]))
      else $error("end cell feedback select wrong");

   // dedicated pins are held away from the array when registers exist
   a_dedicated_pins: assert property (
      !sg0 |=> !clk_pin_arr_ff && !oe_pin_arr_ff)
      else $error("clock or enable pin reached array");

   // flip-flops are clear on release of reset
   a_reset_clear: assert property (
      $rose(rstn) |-> q_all == '0)
      else $error("flip-flops not clear after reset");

   // secured configuration reads back as zero
   a_secure_hide: assert property (
      rd && secure_ff && (addr == REG_CFG) |=> rdata_ff == '0)
      else $error("secured configuration readable");

   // security drops only through a programming erase
   a_sec_clear: assert property (
      $fell(secure_ff) |-> $past(wr_ctrl) && (cfg_ff == CFG_RST))
      else $error("security cleared without erase");

   a_sig_read: assert property (
      rd && (addr == REG_SIG_HI) |=> rdata_ff == $past(sig_ff[SIG_W-1:32]))
      else $error("signature read wrong");
endmodule : mcl_top
`default_nettype wire

//--- mcl_board.sv
// Board-side model of the I/O pins facing the macrocell array
`timescale 1ns/100ps
`default_nettype none
module mcl_board
   import mcl_pkg::*;
(
   input  wire logic             clock,
   input  wire logic [NCELL-1:0] pin_out_ff,
   input  wire logic [NCELL-1:0] pin_oe_ff,
   input  wire logic [NCELL-1:0] ext_val,
   input  wire logic [NCELL-1:0] ext_en,
   output logic      [NCELL-1:0] pin_in
);
   logic [NCELL-1:0] last_ff = 8'h00;
   logic [NCELL-1:0] float_lvl;
   // A floating pin shows the inverse of its last level, so no stale value passes
   assign float_lvl = ~pin_oe_ff & ~ext_en & ~last_ff;
   // Board drives pins while the cell buffers are off, as for preload
   assign pin_in = (pin_oe_ff & pin_out_ff) | (~pin_oe_ff & ext_en & ext_val) | float_lvl;
   always_ff @(posedge clock) begin
      last_ff <= pin_in;
   end
endmodule : mcl_board
`default_nettype wire

//--- macrocell_config_logic_tb.sv
// Self-checking testbench for the eight-cell macrocell array
`timescale 1ns/100ps
`default_nettype none
module macrocell_config_logic_tb
   import mcl_pkg::*;
;
   logic                 clock = 1'h0;
   logic                 rstn;
   logic [ADDR_W-1:0]    addr;
   logic [DATA_W-1:0]    wdata;
   logic                 wr;
   logic                 rd;
   logic [DATA_W-1:0]    rdata_ff;
   logic [NCELL*NPT-1:0] pterms;
   logic [NCELL-1:0]     pin_in, pin_out_ff, pin_oe_ff, fb_ff, ext_val, ext_en;
   logic                 clk_pin_in, oe_pin_n_in, clk_pin_arr_ff, oe_pin_arr_ff;
   int                   fails;
   int                   n_checks;

   always #25 clock = ~clock;

   mcl_top DUT (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata_ff(rdata_ff), .pterms(pterms), .pin_in(pin_in),
      .clk_pin_in(clk_pin_in), .oe_pin_n_in(oe_pin_n_in), .pin_out_ff(pin_out_ff),
      .pin_oe_ff(pin_oe_ff), .fb_ff(fb_ff), .clk_pin_arr_ff(clk_pin_arr_ff),
      .oe_pin_arr_ff(oe_pin_arr_ff));

   mcl_board board (.clock(clock), .pin_out_ff(pin_out_ff), .pin_oe_ff(pin_oe_ff),
      .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

   task automatic end_sim();
      if (fails == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk8

   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk32

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clock);
      wr    <= 1'h1;
      addr  <= a;
      wdata <= d;
      @(posedge clock);
      wr    <= 1'h0;
   endtask : wr_reg

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clock);
      rd   <= 1'h1;
      addr <= a;
      @(posedge clock);
      rd   <= 1'h0;
      #1;
      chk32("rdata", exp, rdata_ff);
   endtask : rd_chk

   // Covers two synchroniser flops, the cell flop and the output flop
   task automatic settle();
      repeat (5) @(posedge clock);
      #1;
   endtask : settle

   task automatic set_pt(input logic [NCELL*NPT-1:0] p);
      @(posedge clock);
      pterms <= p;
   endtask : set_pt

   task automatic t_reset();
      #1;
      chk8("oe after reset", 8'h00, pin_oe_ff);
      rd_chk(REG_STATUS, 32'h0000FF00);
      wr_reg(REG_CTRL, 32'h2);
      settle();
      chk8("registered out", 8'hFF, pin_out_ff);
      chk8("registered oe", 8'hFF, pin_oe_ff);
      chk8("clock pin to array", 8'h00, {7'h0, clk_pin_arr_ff});
      chk8("oe pin to array", 8'h00, {7'h0, oe_pin_arr_ff});
      rd_chk(REG_STATUS, 32'h0);
      @(posedge clock);
      oe_pin_n_in <= 1'h1;
      settle();
      chk8("registered oe off", 8'h00, pin_oe_ff);
      @(posedge clock);
      oe_pin_n_in <= 1'h0;
   endtask : t_reset

   task automatic t_reg();
      wr_reg(REG_POL, 32'h02);
      set_pt(64'h0000000000000080);
      settle();
      chk8("registered out", 8'hFC, pin_out_ff);
      chk8("registered fb", 8'hFC, fb_ff);
      rd_chk(REG_STATUS, 32'h00030000);
      set_pt(64'h0);
      settle();
      chk8("registered recapture", 8'hFD, pin_out_ff);
   endtask : t_reg

   task automatic t_comb_out();
      wr_reg(REG_CTRL, 32'h1);
      wr_reg(REG_POL, 32'h80);
      set_pt(64'h0080008000800080);
      @(posedge clock);
      oe_pin_n_in <= 1'h1;
      settle();
      chk8("comb out", 8'hD5, pin_out_ff);
      chk8("comb oe", 8'hFF, pin_oe_ff);
      chk8("comb fb", 8'hC5, fb_ff);
      chk8("clock pin to array", 8'h01, {7'h0, clk_pin_arr_ff});
      chk8("oe pin to array", 8'h01, {7'h0, oe_pin_arr_ff});
      @(posedge clock);
      oe_pin_n_in <= 1'h0;
   endtask : t_comb_out

   task automatic t_ded_in();
      wr_reg(REG_CFG, 32'hFF);
      @(posedge clock);
      ext_en  <= 8'hFF;
      ext_val <= 8'hA6;
      settle();
      chk8("input oe", 8'h00, pin_oe_ff);
      chk8("adjacent fb", 8'h41, fb_ff);
      // Cell 1 flop still holds the value captured in the registered scenario
      rd_chk(REG_STATUS, 32'h00021800);
   endtask : t_ded_in

   // End cells pick the neighbour pin when registers are not allowed
   task automatic t_comb_io(input logic [1:0] mode, input logic [7:0] exp_fb);
      wr_reg(REG_CTRL, {30'h0, mode});
      wr_reg(REG_CFG, 32'hFF);
      set_pt(64'h0101010180818081);
      settle();
      chk8("io oe", 8'h0F, pin_oe_ff);
      chk8("io out", 8'h05, pin_out_ff & 8'h0F);
      chk8("io fb", exp_fb, fb_ff);
   endtask : t_comb_io

   task automatic t_preload();
      wr_reg(REG_CTRL, 32'h2);
      set_pt(64'h0);
      ext_val <= 8'h5A;
      wr_reg(REG_TEST, 32'h1);
      settle();
      chk8("preload oe", 8'h00, pin_oe_ff);
      rd_chk(REG_STATUS, 32'h005A0000);
      wr_reg(REG_TEST, 32'h0);
      settle();
      chk8("after preload", 8'hFF, pin_out_ff);
   endtask : t_preload

   task automatic t_secure();
      wr_reg(REG_CTRL, 32'h1);
      wr_reg(REG_CFG, 32'h44);
      wr_reg(REG_SIG_LO, 32'h89ABCDEF);
      wr_reg(REG_SIG_HI, 32'h01234567);
      rd_chk(REG_CFG, 32'h44);
      wr_reg(REG_SECURE, 32'h1);
      rd_chk(REG_STATUS, 32'h1);
      rd_chk(REG_CFG, 32'h0);
      rd_chk(REG_CTRL, 32'h0);
      rd_chk(REG_SIG_LO, 32'h89ABCDEF);
      rd_chk(REG_SIG_HI, 32'h01234567);
      @(posedge clock);
      #1;
      chk32("rdata idle", 32'h0, rdata_ff);
      wr_reg(REG_CFG, 32'h18);
      wr_reg(8'h40, 32'hFFFFFFFF);
      rd_chk(REG_STATUS, 32'h1);
      rd_chk(8'h40, 32'h0);
      wr_reg(REG_CTRL, 32'h1);
      rd_chk(REG_STATUS, 32'h0);
      rd_chk(REG_CFG, 32'h0);
      rd_chk(REG_SIG_LO, 32'h0);
   endtask : t_secure

   initial begin
      rstn        = 1'h0;
      addr        = 8'h00;
      wdata       = 32'h0;
      wr          = 1'h0;
      rd          = 1'h0;
      pterms      = 64'h0;
      clk_pin_in  = 1'h1;
      oe_pin_n_in = 1'h0;
      ext_val     = 8'h00;
      ext_en      = 8'h00;
      fails       = 0;
      n_checks    = 0;
      repeat (3) @(posedge clock);
      rstn <= 1'h1;
      @(posedge clock);
      t_reset();
      t_reg();
      t_comb_out();
      t_ded_in();
      t_comb_io(2'h3, 8'h24);
      t_comb_io(2'h2, 8'hA5);
      t_preload();
      t_secure();
      end_sim();
   end

   // Cuts a hang short
   initial begin
      repeat (4000) @(posedge clock);
      fails++;
      end_sim();
   end
endmodule : macrocell_config_logic_tb
`default_nettype wire
